/* bench/tpo_ctrl_props.sv */
// tpo_ctrl_props: port-level checks on tpo_ctrl
// assumes: bound to tpo_ctrl, one clock domain
`timescale 1ns/1ps
module tpo_ctrl_props (
  input wire logic clk_i, // clock
  input wire logic resetn_i, // reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [31:0] s_axi_araddr, // ar addr
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  input wire logic burnout_direction_switch_i, // burnout switch
  input wire logic hw_protect_switch_i, // protect switch
  input wire logic cpu_fail_i, // failure
  input wire logic [15:0] ao_o, // output code
  input wire logic burn_low_o // low burnout
);
  logic fail_r;
  logic wtake;
  logic rtake;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // failure latch, as the block keeps it
  always_ff @(posedge clk_i) begin
    if (!resetn_i) fail_r <= 1'b0;
    else if (cpu_fail_i) fail_r <= 1'b1;
  end
  // handshakes
  assign wtake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rtake = s_axi_arvalid && s_axi_arready;
  property p_lock;
    wtake && hw_protect_switch_i && !fail_r && !cpu_fail_i |=> s_axi_bresp == 2'h2;
  endproperty
  a_lock: assert property (p_lock) else $error("locked write accepted");
  property p_hi;
    fail_r && burnout_direction_switch_i |-> ##[0:2] ao_o >= tpo_pkg::AO_BURN_HIGH;
  endproperty
  a_hi: assert property (p_hi) else $error("high burnout missing");
  property p_lo;
    fail_r && !burnout_direction_switch_i |-> ##[0:2] burn_low_o;
  endproperty
  a_lo: assert property (p_lo) else $error("low burnout missing");
  property p_bq;
    fail_r && !s_axi_bvalid |=> !s_axi_bvalid;
  endproperty
  a_bq: assert property (p_bq) else $error("write answered after failure");
  property p_rq;
    fail_r && !s_axi_rvalid |=> !s_axi_rvalid;
  endproperty
  a_rq: assert property (p_rq) else $error("read answered after failure");
  property p_bans;
    wtake && !fail_r && !cpu_fail_i |=> s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("write not answered");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_dir;
    rtake && s_axi_araddr[7:0] == tpo_pkg::REG_STATUS && !fail_r && !cpu_fail_i
      |=> s_axi_rdata[0] == $past(burnout_direction_switch_i);
  endproperty
  a_dir: assert property (p_dir) else $error("direction bit wrong");
  c_fail: cover property (fail_r && burn_low_o);
  c_lock: cover property (wtake && hw_protect_switch_i);
  c_dir: cover property (rtake && s_axi_araddr[7:0] == tpo_pkg::REG_STATUS);
endmodule
bind tpo_ctrl tpo_ctrl_props tpo_ctrl_props_inst (.clk_i, .resetn_i, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .burnout_direction_switch_i, .hw_protect_switch_i, .cpu_fail_i, .ao_o, .burn_low_o);

/* bench/tpo_ctrl_tb.sv */
// tpo_ctrl_tb: self-checking bench for tpo_ctrl
// assumes: tpo_host drives the register bus, release window shortened to 50 cycles
`timescale 1ns/1ps
module tpo_ctrl_tb;
  localparam int RC = 50;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic sw = 1'b1;
  logic hw = 1'b0;
  logic fail = 1'b0;
  logic [15:0] pres = 16'h0;
  logic [15:0] temp = 16'h0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp;
  logic [15:0] ao;
  logic burn_low;
  logic [5:0] alarm;
  int n_fail = 0;
  int compares = 0;
  initial forever #25 clk_i = ~clk_i;
  tpo_host tpo_host_inst (.clk_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
  tpo_ctrl #(.RELEASE_CYCLES(RC)) tpo_ctrl_inst (.clk_i, .resetn_i, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp(), .s_axi_rvalid, .s_axi_rready,
    .burnout_direction_switch_i(sw), .hw_protect_switch_i(hw), .cpu_fail_i(fail),
    .pres_i(pres), .spres_i(16'h0), .temp_i(temp), .ao_o(ao), .burn_low_o(burn_low),
    .alarm_o(alarm));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    tpo_host_inst.wr(a, d, r);
    check({30'h0, r}, {30'h0, e});
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic g;
    tpo_host_inst.rd(a, 200, d, g);
    check({31'h0, g}, 32'h1);
    check(d & m, e);
  endtask
  task automatic do_reset();
    resetn_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
  endtask
  task automatic t_dir();
    for (int i = 0; i < 2; i++) begin
      sw <= i[0];
      @(posedge clk_i);
      rreg(tpo_pkg::REG_STATUS, 32'h1, {31'h0, i[0]});
    end
    hw <= 1'b1;
    wreg(tpo_pkg::REG_CTRL, 32'h4, 2'h2);
    rreg(tpo_pkg::REG_CTRL, 32'h7, 32'h0);
    hw <= 1'b0;
    rreg(8'hF0, 32'hFFFF_FFFF, 32'h0);
    $display("dir done");
  endtask
  task automatic t_pw();
    wreg(tpo_pkg::REG_PW_LO, 32'h4142_4344, 2'h0);
    wreg(tpo_pkg::REG_PW_HI, 32'h4546_4748, 2'h0);
    wreg(tpo_pkg::REG_PW_CMD, 32'h1, 2'h0);
    rreg(tpo_pkg::REG_STATUS, 32'h4, 32'h4);
    wreg(tpo_pkg::REG_NPTS, 32'h3, 2'h2);
    wreg(tpo_pkg::REG_PW_CMD, 32'h2, 2'h0);
    wreg(tpo_pkg::REG_NPTS, 32'h3, 2'h0);
    repeat (RC) @(posedge clk_i);
    wreg(tpo_pkg::REG_NPTS, 32'h2, 2'h2);
    wreg(tpo_pkg::REG_PW_CMD, 32'h2, 2'h0);
    wreg(tpo_pkg::REG_PW_LO, tpo_pkg::SPACES8, 2'h0);
    wreg(tpo_pkg::REG_PW_HI, tpo_pkg::SPACES8, 2'h0);
    wreg(tpo_pkg::REG_PW_CMD, 32'h1, 2'h0);
    rreg(tpo_pkg::REG_STATUS, 32'h4, 32'h0);
    $display("pw done");
  endtask
  task automatic t_sc();
    wreg(tpo_pkg::REG_NPTS, 32'h2, 2'h0);
    wreg(tpo_pkg::REG_PT_BASE, 32'h1000_1000, 2'h0);
    wreg(tpo_pkg::REG_PT_BASE + 8'h4, 32'h0800_2000, 2'h0);
    wreg(tpo_pkg::REG_CTRL, 32'h1, 2'h0);
    rreg(tpo_pkg::REG_STATUS, 32'hFF02, 32'h3C02);
    wreg(tpo_pkg::REG_CTRL, 32'h0, 2'h0);
    wreg(tpo_pkg::REG_PT_BASE + 8'h4, 32'h2000_2000, 2'h0);
    wreg(tpo_pkg::REG_CTRL, 32'h6, 2'h0);
    wreg(tpo_pkg::REG_CTRL, 32'h7, 2'h0);
    rreg(tpo_pkg::REG_STATUS, 32'hFF02, 32'h3C02);
    wreg(tpo_pkg::REG_CTRL, 32'h0, 2'h0);
    wreg(tpo_pkg::REG_CTRL, 32'h1, 2'h0);
    rreg(tpo_pkg::REG_STATUS, 32'h2, 32'h0);
    rreg(tpo_pkg::REG_AO, 32'hFFFF, 32'h1000);
    wreg(tpo_pkg::REG_NPTS, 32'h5, 2'h0);
    rreg(tpo_pkg::REG_NPTS, 32'hF, 32'h2);
    $display("sc done");
  endtask
  task automatic t_alm();
    pres <= 16'h1800;
    wreg(tpo_pkg::REG_ALM_BASE + 8'h4, 32'h1000, 2'h0);
    wreg(tpo_pkg::REG_ALM_BASE + 8'h8, 32'h0800, 2'h0);
    for (int m = 0; m < 4; m++) begin
      wreg(tpo_pkg::REG_ALM_BASE, m, 2'h0);
      repeat (3) @(posedge clk_i);
      check({30'h0, alarm[1:0]}, (m % 2) ? 32'h2 : 32'h0);
    end
    pres <= 16'h0400;
    wreg(tpo_pkg::REG_ALM_BASE + 8'h18, 32'h3, 2'h0);
    wreg(tpo_pkg::REG_ALM_BASE + 8'h20, 32'h0100, 2'h0);
    repeat (3) @(posedge clk_i);
    check({26'h0, alarm}, 32'h11);
    $display("alm done");
  endtask
  task automatic t_fail();
    logic [31:0] d;
    logic g;
    sw <= 1'b0;
    fail <= 1'b1;
    repeat (4) @(posedge clk_i);
    check({31'h0, burn_low}, 32'h1);
    tpo_host_inst.rd(tpo_pkg::REG_STATUS, 20, d, g);
    check({31'h0, g}, 32'h0);
    fail <= 1'b0;
    do_reset();
    sw <= 1'b1;
    fail <= 1'b1;
    repeat (4) @(posedge clk_i);
    check({31'h0, ao >= tpo_pkg::AO_BURN_HIGH}, 32'h1);
    fail <= 1'b0;
    do_reset();
    $display("fail done");
  endtask
  task automatic print_verdict();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    t_dir();
    t_pw();
    t_sc();
    t_alm();
    t_fail();
    print_verdict();
  end
  // watchdog
  initial begin
    #1000000;
    n_fail++;
    print_verdict();
  end
endmodule

/* bench/tpo_host.sv */
// tpo_host: register bus master standing in for the configuration tool
// assumes: shares clk_i with the block, one transfer at a time
`timescale 1ns/1ps
module tpo_host (
  input wire logic clk_i, // clock
  output logic [31:0] s_axi_awaddr = 32'h0, // aw addr
  output logic s_axi_awvalid = 1'b0, // aw valid
  input wire logic s_axi_awready, // aw ready
  output logic [31:0] s_axi_wdata = 32'h0, // w data
  output logic s_axi_wvalid = 1'b0, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  output logic s_axi_bready = 1'b0, // b ready
  output logic [31:0] s_axi_araddr = 32'h0, // ar addr
  output logic s_axi_arvalid = 1'b0, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  output logic s_axi_rready = 1'b0 // r ready
);
  // write: both channels offered, each released once taken, password words sent whole
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge clk_i);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge clk_i); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_i);
  endtask
  // read: gives up after n cycles when the block stays silent
  task automatic rd(input logic [7:0] a, input int n, output logic [31:0] d, output logic g);
    g = 1'b0;
    d = 32'h0;
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (n) begin
      @(posedge clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        g = 1'b1;
        d = s_axi_rdata;
        break;
      end
    end
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule

/* verilog/tpo_ctrl.sv */
// tpo_ctrl: write protection, burnout output, signal characterizer, process alarms
// assumes: switches and process values synchronous to clk_i; -5 % is shown by burn_low_o
`timescale 1ns/1ps
module tpo_ctrl #(
  parameter longint RELEASE_CYCLES = tpo_pkg::RELEASE_CYC,
  parameter int NPTS = tpo_pkg::NPTS_MAX
) (
  input wire logic clk_i, // 20 MHz clock
  input wire logic resetn_i, // synchronous reset, active low
  input wire logic [31:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // response valid
  input wire logic s_axi_bready, // response ready
  input wire logic [31:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic burnout_direction_switch_i, // 1 = high, 0 = low
  input wire logic hw_protect_switch_i, // 1 = write disabled
  input wire logic cpu_fail_i, // cpu failure detected
  input wire logic [15:0] pres_i, // pressure, 0..PCT_FULL
  input wire logic [15:0] spres_i, // static pressure
  input wire logic [15:0] temp_i, // capsule temperature
  output logic [15:0] ao_o, // analog output code
  output logic burn_low_o, // drive output to -5 % or below
  output logic [5:0] alarm_o // {temp,sp,pres} x {hi,lo}
);
  localparam int CW = 34;
  // bus response codes, strobe pattern and alarm register layout
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [3:0] WSTRB_ALL = 4'hF;
  localparam int ALM_STRIDE = 12;
  localparam int ALM_UPPER_OFS = 4;
  localparam int ALM_LOWER_OFS = 8;
  // refuse parameters the logic cannot serve
  initial begin
    if (NPTS < 1 || NPTS > tpo_pkg::NPTS_MAX) $error("NPTS out of range");
    if (RELEASE_CYCLES < 1) $error("RELEASE_CYCLES must be positive");
    if (RELEASE_CYCLES >= (longint'(1) << CW)) $error("RELEASE_CYCLES too wide for counter");
  end

  logic failed_r;
  logic protect_r;
  logic sc_en_r;
  logic sqrt_r;
  logic lcut_lin_r;
  logic sc_reject_r;
  logic [63:0] pw_stage_r;
  logic [63:0] pw_r;
  logic [3:0] npts_r;
  logic [CW-1:0] rel_cnt_r;
  tpo_pkg::tpo_point_t pts_r [NPTS];
  tpo_pkg::tpo_alm_mode_t amode_r [3];
  logic [15:0] upper_r [3];
  logic [15:0] lower_r [3];
  logic [15:0] pv [3];
  assign pv[0] = pres_i;
  assign pv[1] = spres_i;
  assign pv[2] = temp_i;

  // axi write channel: both taken together when neither is pending response
  logic wr_go;
  logic rd_go;
  logic [7:0] waddr;
  logic [7:0] raddr;
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready = s_axi_awready;
  assign wr_go = s_axi_awready;
  assign waddr = s_axi_awaddr[7:0];
  assign s_axi_arready = s_axi_arvalid && !s_axi_rvalid;
  assign rd_go = s_axi_arready;
  assign raddr = s_axi_araddr[7:0];

  // write permission
  logic rel_open;
  logic locked;
  logic wr_ok;
  assign rel_open = rel_cnt_r != '0;
  assign locked = hw_protect_switch_i || (protect_r && !rel_open);
  assign wr_ok = wr_go && !locked && !failed_r && s_axi_wstrb == WSTRB_ALL;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // point table index from address
  function automatic int pt_idx(input logic [7:0] a);
    return int'(a - tpo_pkg::REG_PT_BASE) >> 2;
  endfunction

  // byte address of word k (0 mode, 4 upper, 8 lower) of alarm variable v
  function automatic logic [7:0] alm_addr(input int v, input int k);
    return tpo_pkg::REG_ALM_BASE + 8'(ALM_STRIDE * v + k);
  endfunction

  // write decodes
  logic wr_ctrl;
  logic wr_npts;
  logic wr_pw_lo;
  logic wr_pw_hi;
  logic wr_pw_cmd;
  logic wr_pt;
  assign wr_ctrl = hit(waddr, tpo_pkg::REG_CTRL);
  assign wr_npts = hit(waddr, tpo_pkg::REG_NPTS);
  assign wr_pw_lo = hit(waddr, tpo_pkg::REG_PW_LO);
  assign wr_pw_hi = hit(waddr, tpo_pkg::REG_PW_HI);
  assign wr_pw_cmd = hit(waddr, tpo_pkg::REG_PW_CMD);
  assign wr_pt = waddr >= tpo_pkg::REG_PT_BASE && pt_idx(waddr) < NPTS;

  // monotonic check across active points
  logic mono_ok;
  logic mode_ok;
  always_comb begin
    mono_ok = 1'b1;
    for (int i = 1; i < NPTS; i++) begin
      if (i < int'(npts_r) &&
          (pts_r[i].x <= pts_r[i-1].x || pts_r[i].y <= pts_r[i-1].y)) begin
        mono_ok = 1'b0;
      end
    end
  end
  assign mode_ok = !(sqrt_r && lcut_lin_r);
  // activation allowed only with monotonic points and a legal mode
  logic sc_go;
  assign sc_go = mono_ok && mode_ok;

  // latch cpu failure until reset
  always_ff @(posedge clk_i) begin
    if (!resetn_i) failed_r <= 1'b0;
    else if (cpu_fail_i) failed_r <= 1'b1;
  end

  // password commands and protect status
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pw_stage_r <= '0;
      pw_r <= '0;
      protect_r <= 1'b0;
    end else if (wr_ok) begin
      if (wr_pw_lo) pw_stage_r[31:0] <= s_axi_wdata;
      if (wr_pw_hi) pw_stage_r[63:32] <= s_axi_wdata;
      if (wr_pw_cmd && s_axi_wdata[tpo_pkg::CMD_NEW_PW]) begin
        pw_r <= pw_stage_r;
        protect_r <= pw_stage_r != {tpo_pkg::SPACES8, tpo_pkg::SPACES8};
      end
    end
  end

  // timed release window; the command itself may arrive while the password lock holds, not while hw_protect_switch_i is set
  logic rel_hit;
  // staged word must equal the stored password
  logic pw_match;
  assign pw_match = pw_stage_r == pw_r;
  assign rel_hit = wr_go && !hw_protect_switch_i && !failed_r && protect_r &&
                   wr_pw_cmd && s_axi_wdata[tpo_pkg::CMD_RELEASE] && pw_match;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) rel_cnt_r <= '0;
    else if (rel_hit) rel_cnt_r <= CW'(RELEASE_CYCLES);
    else if (rel_open) rel_cnt_r <= rel_cnt_r - CW'(1);
  end

  // point count must fit the table; upper bits must be clear
  logic npts_ok;
  assign npts_ok = s_axi_wdata[31:4] == '0 && s_axi_wdata[3:0] <= 4'(NPTS);
  // characterizer configuration and enable
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sc_en_r <= 1'b0;
      sqrt_r <= 1'b0;
      lcut_lin_r <= 1'b0;
      sc_reject_r <= 1'b0;
      npts_r <= '0;
      for (int i = 0; i < NPTS; i++) pts_r[i] <= '0;
    end else if (wr_ok) begin
      if (wr_ctrl) begin
        sqrt_r <= s_axi_wdata[tpo_pkg::CTRL_SQRT];
        lcut_lin_r <= s_axi_wdata[tpo_pkg::CTRL_LCUT_LIN];
        if (s_axi_wdata[tpo_pkg::CTRL_SC_EN] && !sc_en_r) begin
          sc_en_r <= sc_go;
          sc_reject_r <= !sc_go;
        end else if (!s_axi_wdata[tpo_pkg::CTRL_SC_EN]) begin
          sc_en_r <= 1'b0;
          sc_reject_r <= 1'b0;
        end
      end
      if (!sc_en_r && wr_npts && npts_ok) begin
        npts_r <= s_axi_wdata[3:0];
      end
      if (!sc_en_r && wr_pt) begin
        pts_r[pt_idx(waddr)] <= s_axi_wdata;
      end
    end
  end

  // alarm modes and thresholds
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      for (int v = 0; v < 3; v++) begin
        amode_r[v] <= tpo_pkg::ALM_OFF;
        upper_r[v] <= tpo_pkg::PCT_FULL;
        lower_r[v] <= '0;
      end
    end else if (wr_ok) begin
      for (int v = 0; v < 3; v++) begin
        if (hit(waddr, alm_addr(v, 0)))
          amode_r[v] <= tpo_pkg::tpo_alm_mode_t'(s_axi_wdata[1:0]);
        if (hit(waddr, alm_addr(v, ALM_UPPER_OFS)))
          upper_r[v] <= s_axi_wdata[15:0];
        if (hit(waddr, alm_addr(v, ALM_LOWER_OFS)))
          lower_r[v] <= s_axi_wdata[15:0];
      end
    end
  end

  // alarm comparison
  always_ff @(posedge clk_i) begin
    if (!resetn_i) alarm_o <= '0;
    else begin
      for (int v = 0; v < 3; v++) begin
        alarm_o[2*v+1] <= (amode_r[v] == tpo_pkg::ALM_HIGH || amode_r[v] == tpo_pkg::ALM_BOTH)
                          && pv[v] > upper_r[v];
        alarm_o[2*v] <= (amode_r[v] == tpo_pkg::ALM_LOW || amode_r[v] == tpo_pkg::ALM_BOTH)
                        && pv[v] < lower_r[v];
      end
    end
  end

  // piecewise linear characterizer
  logic [15:0] char_y;
  always_comb begin
    logic [31:0] num;
    logic [15:0] dx;
    num = '0;
    dx = '0;
    char_y = pres_i;
    if (npts_r != '0 && pres_i <= pts_r[0].x) char_y = pts_r[0].y;
    for (int i = 1; i < NPTS; i++) begin
      if (i < int'(npts_r) && pres_i > pts_r[i-1].x) begin
        if (pres_i >= pts_r[i].x) char_y = pts_r[i].y;
        else begin
          dx = pts_r[i].x - pts_r[i-1].x;
          num = 32'(pres_i - pts_r[i-1].x) * 32'(pts_r[i].y - pts_r[i-1].y);
          char_y = pts_r[i-1].y + 16'(num / 32'(dx));
        end
      end
    end
  end

  // analog output with burnout override
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ao_o <= '0;
      burn_low_o <= 1'b0;
    end else if (failed_r) begin
      ao_o <= burnout_direction_switch_i ? tpo_pkg::AO_BURN_HIGH : tpo_pkg::AO_BURN_LOW;
      burn_low_o <= !burnout_direction_switch_i;
    end else begin
      ao_o <= sc_en_r ? char_y : pres_i;
      burn_low_o <= 1'b0;
    end
  end

  // a timed release command is acknowledged even while the password lock blocks other writes, but not while hw_protect_switch_i is set
  logic bresp_ok;
  assign bresp_ok = wr_ok || rel_hit;

  // write response; silent after failure
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go && !failed_r) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= bresp_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
  end

  // read mux
  logic [31:0] rmux;
  always_comb begin
    rmux = '0;
    unique case (raddr)
      tpo_pkg::REG_CTRL: rmux = {29'h0, lcut_lin_r, sqrt_r, sc_en_r};
      tpo_pkg::REG_STATUS: rmux = {16'h0, sc_reject_r ? tpo_pkg::ALM_CODE_SC : 8'h00,
                                   2'b00, failed_r, hw_protect_switch_i, rel_open,
                                   protect_r, sc_reject_r,
                                   burnout_direction_switch_i};
      tpo_pkg::REG_NPTS: rmux = {28'h0, npts_r};
      tpo_pkg::REG_PVAL: rmux = {16'h0, pres_i};
      tpo_pkg::REG_AO: rmux = {15'h0, burn_low_o, ao_o};
      default: begin
        if (raddr >= tpo_pkg::REG_PT_BASE && pt_idx(raddr) < NPTS) rmux = pts_r[pt_idx(raddr)];
        for (int v = 0; v < 3; v++) begin
          if (hit(raddr, alm_addr(v, 0))) rmux = {30'h0, amode_r[v]};
          if (hit(raddr, alm_addr(v, ALM_UPPER_OFS))) rmux = {16'h0, upper_r[v]};
          if (hit(raddr, alm_addr(v, ALM_LOWER_OFS))) rmux = {16'h0, lower_r[v]};
        end
      end
    endcase
  end

  // read response; silent after failure
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (rd_go && !failed_r) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rmux;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end
endmodule

/* verilog/tpo_pkg.sv */
// tpo_pkg: shared constants and types for the transmitter protect/output control
// assumes: 20 MHz clock, 32-bit axi4-lite register bus, 16-bit unsigned process values
package tpo_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;   // sc enable, output mode, low-cut mode
  localparam logic [7:0] REG_STATUS = 8'h04; // read-only state
  localparam logic [7:0] REG_PW_LO = 8'h08;  // password staging chars 0..3
  localparam logic [7:0] REG_PW_HI = 8'h0C;  // password staging chars 4..7
  localparam logic [7:0] REG_PW_CMD = 8'h10; // write action: new password / timed release
  localparam logic [7:0] REG_NPTS = 8'h14;   // characterizer point count
  localparam logic [7:0] REG_PT_BASE = 8'h20; // 9 points, x in [31:16], y in [15:0]
  localparam logic [7:0] REG_ALM_BASE = 8'h50; // per variable: mode, upper, lower (3 words)
  localparam logic [7:0] REG_PVAL = 8'h80;   // pressure value 0..100% read back
  localparam logic [7:0] REG_AO = 8'h84;     // analog output code read back
  // field positions
  localparam int CTRL_SC_EN = 0;
  localparam int CTRL_SQRT = 1;
  localparam int CTRL_LCUT_LIN = 2;
  localparam int CMD_NEW_PW = 0;
  localparam int CMD_RELEASE = 1;
  // analog scale: 0..100% maps onto 0..FULL
  localparam logic [15:0] PCT_FULL = 16'h2710;     // 100.00 %
  localparam logic [15:0] AO_BURN_HIGH = 16'h2AF8; // 110.00 %
  localparam logic [15:0] AO_BURN_LOW = 16'h0000;  // -5 % offset zero: below 0 code
  localparam logic [31:0] SPACES8 = 32'h2020_2020;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int RELEASE_MIN = 10;
  localparam longint RELEASE_CYC = longint'(RELEASE_MIN) * 60 * CLK_HZ;
  localparam int NPTS_MAX = 9;
  // alarm code shown in the status register
  localparam logic [7:0] ALM_CODE_SC = 8'h3C; // characterizer reject (60)
  typedef enum logic [1:0] {
    ALM_OFF, ALM_HIGH, ALM_LOW, ALM_BOTH
  } tpo_alm_mode_t;
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
  } tpo_point_t;
  typedef struct packed {
    logic hi;
    logic lo;
  } tpo_alarm_t;
endpackage
